// *** logic/rtca_params.svh ***
`ifndef RTCA_PARAMS_SVH
`define RTCA_PARAMS_SVH

// register byte offsets on the bus
`define RTCA_OFF_CFG       8'h00
`define RTCA_OFF_WIN       8'h04
`define RTCA_OFF_MD        8'h08
`define RTCA_OFF_WH        8'h0C
`define RTCA_OFF_MS        8'h10
`define RTCA_OFF_CAL       8'h14
`define RTCA_OFF_STAT      8'h18

// implemented bits of the three alarm value registers
`define RTCA_MD_BITS       16'h1F3F
`define RTCA_WH_BITS       16'h073F
`define RTCA_MS_BITS       16'h7F7F

// alarm config field positions
`define RTCA_CFG_EN        15
`define RTCA_CFG_CHIME     14
`define RTCA_CFG_MASK_HI   13
`define RTCA_CFG_MASK_LO   10
`define RTCA_CFG_PTR_HI    9
`define RTCA_CFG_PTR_LO    8
`define RTCA_CFG_RPT_HI    7

// calibration register field positions
`define RTCA_CAL_WREN      15
`define RTCA_CAL_TRIM_HI   7

// reset values
`define RTCA_CFG_RST       16'h0000
`define RTCA_VAL_RST       16'h0000
`define RTCA_TRIM_RST      8'h00

// counts
`define RTCA_RPT_WRAP      8'hFF
`define RTCA_TRIM_SHIFT    2
`define RTCA_PTR_MD        2'h2
`define RTCA_PTR_WH        2'h1
`define RTCA_PTR_MS        2'h0

// bus responses
`define RTCA_RESP_OKAY     2'h0
`define RTCA_RESP_SLVERR   2'h2

`endif

// *** logic/rtca_pkg.sv ***
package rtca_pkg;

	// alarm interval mask codes
	typedef enum logic [3:0] {
		RTCA_M_HALF  = 4'h0,
		RTCA_M_SEC   = 4'h1,
		RTCA_M_10S   = 4'h2,
		RTCA_M_MIN   = 4'h3,
		RTCA_M_10M   = 4'h4,
		RTCA_M_HOUR  = 4'h5,
		RTCA_M_DAY   = 4'h6,
		RTCA_M_WEEK  = 4'h7,
		RTCA_M_MONTH = 4'h8,
		RTCA_M_YEAR  = 4'h9
	} rtca_mask_t;

	// bcd time value, same layout as the alarm value registers
	typedef struct packed {
		logic [15:0] month_day;
		logic [15:0] weekday_hour;
		logic [15:0] minute_second;
	} rtca_time_t;

endpackage

// *** logic/rtca_trim.sv ***
`timescale 1ns/1ps
`include "rtca_params.svh"

// once-a-minute timebase trim: swallows or inserts 4*|trim| ticks
module rtca_trim import rtca_pkg::*; (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       raw_tick,
	input  wire logic       minute_tick,
	input  wire logic [7:0] trim,
	output logic            adj_tick_ff,
	output logic            busy_ff
);

	logic [9:0] left_ff;   // pulses still to adjust
	logic       remove_ff; // direction latched at minute start
	logic [7:0] mag;       // trim magnitude

	assign mag = trim[7] ? 8'(-trim) : trim;

	// adjustment counter and direction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			left_ff   <= 10'h000;
			remove_ff <= 1'b0;
		end else if (minute_tick) begin
			left_ff   <= {mag, 2'b00};
			remove_ff <= trim[7];
		end else if (left_ff != 10'h000) begin
			if (remove_ff && raw_tick) begin
				left_ff <= left_ff - 10'h001;
			end else if (!remove_ff && !raw_tick) begin
				left_ff <= left_ff - 10'h001;
			end
		end
	end

	// adjusted tick: drop real ticks or fill idle cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adj_tick_ff <= 1'b0;
			busy_ff     <= 1'b0;
		end else begin
			busy_ff <= (left_ff != 10'h000);
			if (minute_tick || left_ff == 10'h000) begin
				adj_tick_ff <= raw_tick;
			end else if (remove_ff) begin
				adj_tick_ff <= 1'b0;
			end else begin
				adj_tick_ff <= 1'b1;
			end
		end
	end

endmodule

// *** logic/rtca_alarm.sv ***
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "rtca_params.svh"

module rtca_alarm import rtca_pkg::*; (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// calendar clock unit side
	input  wire logic        timebase_in,
	input  wire logic        half_tick,
	input  wire logic        second_phase,
	input  wire logic        minute_tick,
	input  wire rtca_time_t  time_now,
	output logic             timebase_tick_ff,
	output logic             alarm_irq_ff,
	output logic             alarm_pulse_ff
);

	// register state
	logic [15:0] cfg_ff;            // alarm_config_register
	logic [15:0] md_ff;             // alarm_month_day
	logic [15:0] wh_ff;             // alarm_weekday_hour
	logic [15:0] ms_ff;             // alarm_minute_second
	logic        wren_ff;           // clock_write_enable
	logic [7:0]  trim_ff;           // trim byte of clock_config_trim_register
	logic        trim_busy;         // trim still adjusting this minute
	logic [1:0]  tb_sync_ff;        // timebase pin synchroniser
	logic        tb_prev_ff;        // previous synchronised timebase level
	logic        raw_tick;          // timebase rising edge

	// bus handshake state
	logic [7:0]  aw_addr_ff;        // latched write address
	logic        aw_have_ff;        // write address held
	logic [31:0] w_data_ff;         // latched write data
	logic [3:0]  w_strb_ff;         // latched write strobes
	logic        w_have_ff;         // write data held
	logic        wr_go;             // both halves held, no response pending
	logic        rd_go;             // read address taken this cycle

	// alarm decision
	logic        alarm_hit;         // alarm event this cycle
	logic        en;                // alarm_enable view
	logic        chime;             // chime view
	logic [3:0]  alarm_interval_mask;             // alarm_interval_mask view
	logic [1:0]  ptr;               // alarm_window_pointer view
	logic [7:0]  rpt;               // alarm_repeat_count view

	assign en    = cfg_ff[`RTCA_CFG_EN];
	assign chime = cfg_ff[`RTCA_CFG_CHIME];
	assign alarm_interval_mask = cfg_ff[`RTCA_CFG_MASK_HI:`RTCA_CFG_MASK_LO];
	assign ptr   = cfg_ff[`RTCA_CFG_PTR_HI:`RTCA_CFG_PTR_LO];
	assign rpt   = cfg_ff[`RTCA_CFG_RPT_HI:0];

	// digits that must match for a mask code, laid out as time_now
	function automatic logic [47:0] cmp_bits(input logic [3:0] code);
		logic [47:0] b;
		b = 48'h0000_0000_0000;
		unique case (code)
			RTCA_M_10S:   b = 48'h0000_0000_000F;
			RTCA_M_MIN:   b = 48'h0000_0000_007F;
			RTCA_M_10M:   b = 48'h0000_0000_0F7F;
			RTCA_M_HOUR:  b = 48'h0000_0000_7F7F;
			RTCA_M_DAY:   b = 48'h0000_003F_7F7F;
			RTCA_M_WEEK:  b = 48'h0000_073F_7F7F;
			RTCA_M_MONTH: b = 48'h003F_003F_7F7F;
			RTCA_M_YEAR:  b = 48'h1F3F_003F_7F7F;
			default:      b = 48'h0000_0000_0000;
		endcase
		return b;
	endfunction

	// true when the alarm fires on this tick
	function automatic logic alarm_match(input logic [3:0] code, input rtca_time_t now,
		input logic [47:0] alm, input logic phase);
		logic [47:0] diff;
		diff = (alm ^ now) & cmp_bits(code);
		if (code == RTCA_M_HALF) begin
			return 1'b1;
		end else if (code > RTCA_M_YEAR) begin
			return 1'b0;
		end else begin
			return phase && (diff == 48'h0000_0000_0000);
		end
	endfunction

	// value register write with implemented-bit masking
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s, input logic [15:0] bits);
		logic [15:0] n;
		n = old;
		if (s[0]) n[7:0] = d[7:0];
		if (s[1]) n[15:8] = d[15:8];
		return n & bits;
	endfunction

	assign alarm_hit = half_tick && en
		&& alarm_match(alarm_interval_mask, time_now, {md_ff, wh_ff, ms_ff}, second_phase);

	// timebase pin synchroniser and edge detect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tb_sync_ff <= 2'b00;
			tb_prev_ff <= 1'b0;
		end else begin
			tb_sync_ff <= {tb_sync_ff[0], timebase_in};
			tb_prev_ff <= tb_sync_ff[1];
		end
	end
	assign raw_tick = tb_sync_ff[1] && !tb_prev_ff;

	// write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_ff <= 1'b0;
			end
		end
	end
	assign wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;

	// ready flags: one item held per channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_ff && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_have_ff && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RTCA_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr_ff > `RTCA_OFF_STAT || aw_addr_ff[1:0] != 2'b00)
				? `RTCA_RESP_SLVERR : `RTCA_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// calibration register: write enable and trim byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wren_ff <= 1'b0;
			trim_ff <= `RTCA_TRIM_RST;
		end else if (wr_go && aw_addr_ff == `RTCA_OFF_CAL) begin
			if (w_strb_ff[1]) wren_ff <= w_data_ff[`RTCA_CAL_WREN];
			if (w_strb_ff[0]) trim_ff <= w_data_ff[`RTCA_CAL_TRIM_HI:0];
		end
	end

	// alarm value registers, direct and through the window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			md_ff <= `RTCA_VAL_RST;
			wh_ff <= `RTCA_VAL_RST;
			ms_ff <= `RTCA_VAL_RST;
		end else if (wr_go) begin
			if (aw_addr_ff == `RTCA_OFF_MD && wren_ff) begin
				md_ff <= merge16(md_ff, w_data_ff, w_strb_ff, `RTCA_MD_BITS);
			end
			if (aw_addr_ff == `RTCA_OFF_WH && wren_ff) begin
				wh_ff <= merge16(wh_ff, w_data_ff, w_strb_ff, `RTCA_WH_BITS);
			end
			if (aw_addr_ff == `RTCA_OFF_MS) begin
				ms_ff <= merge16(ms_ff, w_data_ff, w_strb_ff, `RTCA_MS_BITS);
			end
			if (aw_addr_ff == `RTCA_OFF_WIN) begin
				unique case (ptr)
					`RTCA_PTR_MD: if (wren_ff) md_ff <= merge16(md_ff, w_data_ff, w_strb_ff,
						`RTCA_MD_BITS);
					`RTCA_PTR_WH: if (wren_ff) wh_ff <= merge16(wh_ff, w_data_ff, w_strb_ff,
						`RTCA_WH_BITS);
					`RTCA_PTR_MS: ms_ff <= merge16(ms_ff, w_data_ff, w_strb_ff,
						`RTCA_MS_BITS);
					default: ;
				endcase
			end
		end
	end

	// alarm config: software write, else alarm bookkeeping, plus pointer walk
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff <= `RTCA_CFG_RST;
		end else begin
			if (wr_go && aw_addr_ff == `RTCA_OFF_CFG) begin
				if (w_strb_ff[1]) cfg_ff[15:8] <= w_data_ff[15:8];
				if (w_strb_ff[0]) cfg_ff[7:0] <= w_data_ff[7:0];
			end else begin
				if (alarm_hit) begin
					if (rpt != 8'h00) begin
						cfg_ff[`RTCA_CFG_RPT_HI:0] <= rpt - 8'h01;
					end else if (chime) begin
						cfg_ff[`RTCA_CFG_RPT_HI:0] <= `RTCA_RPT_WRAP;
					end else begin
						cfg_ff[`RTCA_CFG_EN] <= 1'b0;
					end
				end
				// upper half touched: read always, write when lane 1 strobed
				if (ptr != 2'b00 && ((wr_go && aw_addr_ff == `RTCA_OFF_WIN && w_strb_ff[1])
					|| (rd_go && s_axi_araddr == `RTCA_OFF_WIN))) begin
					cfg_ff[`RTCA_CFG_PTR_HI:`RTCA_CFG_PTR_LO] <= ptr - 2'b01;
				end
			end
		end
	end

	// alarm outputs: request pulse and half-rate toggle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_irq_ff   <= 1'b0;
			alarm_pulse_ff <= 1'b0;
		end else begin
			alarm_irq_ff <= alarm_hit;
			if (alarm_hit) alarm_pulse_ff <= !alarm_pulse_ff;
		end
	end

	// read channel
	assign rd_go = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RTCA_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RTCA_RESP_OKAY;
				unique case (s_axi_araddr)
					`RTCA_OFF_CFG:  s_axi_rdata <= {16'h0000, cfg_ff};
					`RTCA_OFF_WIN:  s_axi_rdata <= {16'h0000, (ptr == `RTCA_PTR_MD) ? md_ff :
						(ptr == `RTCA_PTR_WH) ? wh_ff : (ptr == `RTCA_PTR_MS) ? ms_ff :
						16'h0000};
					`RTCA_OFF_MD:   s_axi_rdata <= {16'h0000, md_ff};
					`RTCA_OFF_WH:   s_axi_rdata <= {16'h0000, wh_ff};
					`RTCA_OFF_MS:   s_axi_rdata <= {16'h0000, ms_ff};
					`RTCA_OFF_CAL:  s_axi_rdata <= {16'h0000, wren_ff, 7'h00, trim_ff};
					`RTCA_OFF_STAT: s_axi_rdata <= {30'h0000_0000, trim_busy, alarm_pulse_ff};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RTCA_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// once-a-minute timebase trim
	rtca_trim u_trim (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.raw_tick    (raw_tick),
		.minute_tick (minute_tick),
		.trim        (trim_ff),
		.adj_tick_ff (timebase_tick_ff),
		.busy_ff     (trim_busy)
	);

	// alarm step sequences
	sequence s_hit_final;
		alarm_hit && rpt == 8'h00 && !chime && !(wr_go && aw_addr_ff == `RTCA_OFF_CFG);
	endsequence
	sequence s_hit_wrap;
		alarm_hit && rpt == 8'h00 && chime && !(wr_go && aw_addr_ff == `RTCA_OFF_CFG);
	endsequence

	a_final_disables: assert property (@(posedge aclk) disable iff (!aresetn)
		s_hit_final |=> !en) else $error("alarm enable not cleared after final alarm");
	a_chime_wraps: assert property (@(posedge aclk) disable iff (!aresetn)
		s_hit_wrap |=> en && rpt == 8'hFF) else $error("chime did not wrap repeat count");
	a_repeat_decrements: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_hit && rpt != 8'h00 && !(wr_go && aw_addr_ff == `RTCA_OFF_CFG)
		|=> rpt == $past(rpt) - 8'h01 && en) else $error("repeat count not decremented");
	a_irq_per_alarm: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_irq_ff == $past(alarm_hit)) else $error("interrupt not tied to alarm event");
	a_pulse_toggles: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_hit |=> alarm_pulse_ff != $past(alarm_pulse_ff))
		else $error("alarm pulse did not toggle");
	a_pulse_steady: assert property (@(posedge aclk) disable iff (!aresetn)
		!alarm_hit |=> $stable(alarm_pulse_ff)) else $error("alarm pulse moved without alarm");
	a_tick_only: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_hit |-> half_tick && en && (alarm_interval_mask == 4'h0 || second_phase))
		else $error("alarm outside a half-second tick");
	a_reserved_silent: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_interval_mask > 4'h9 |-> !alarm_hit) else $error("reserved mask code fired");
	a_wren_guard: assert property (@(posedge aclk) disable iff (!aresetn)
		!wren_ff ##1 1'b1 |-> $stable(md_ff) && $stable(wh_ff))
		else $error("alarm date or hour changed while writes locked");
	a_value_bits: assert property (@(posedge aclk) disable iff (!aresetn)
		(md_ff & ~`RTCA_MD_BITS) == 16'h0000 && (wh_ff & ~`RTCA_WH_BITS) == 16'h0000
		&& (ms_ff & ~`RTCA_MS_BITS) == 16'h0000) else $error("unimplemented alarm bits set");

endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "rtca_params.svh"

// self-checking bench: bus tasks, alarm model with logic vectors, trim tick counting
module testbench import rtca_pkg::*; ;

	logic        aclk          = 1'b0;
	logic        aresetn       = 1'b0;
	logic [7:0]  s_axi_awaddr  = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata   = 32'h0;
	logic [3:0]  s_axi_wstrb   = 4'hF;
	logic        s_axi_wvalid  = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready  = 1'b0;
	logic [7:0]  s_axi_araddr  = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready  = 1'b0;
	logic        timebase_in   = 1'b0;
	logic        half_tick     = 1'b0;
	logic        second_phase  = 1'b0;
	logic        minute_tick   = 1'b0;
	rtca_time_t  time_now      = '0;
	logic        timebase_tick_ff;
	logic        alarm_irq_ff;
	logic        alarm_pulse_ff;
	// counters and bench model state
	int          err_total     = 0;
	int          n_tests       = 0;
	int          tb_div        = 0;
	int          tick_cnt      = 0;
	logic [15:0] m_md          = 16'h0000;
	logic [15:0] m_wh          = 16'h0000;
	logic [15:0] m_ms          = 16'h0000;
	logic [7:0]  m_rpt         = 8'h00;
	logic [3:0]  m_mask        = 4'h0;
	logic        m_en          = 1'b0;
	logic        m_ch          = 1'b0;
	logic        m_pulse       = 1'b0;
	logic [1:0]  rsp;
	logic [31:0] rdat;
	logic [47:0] cmpm [16];

	// 20 MHz clock
	always #25 aclk = ~aclk;

	rtca_alarm rtca_alarm_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timebase_in, .half_tick,
		.second_phase, .minute_tick, .time_now, .timebase_tick_ff, .alarm_irq_ff,
		.alarm_pulse_ff
	);

	// raw timebase, one rising edge every 32 cycles
	always @(posedge aclk) begin
		tb_div <= tb_div + 1;
		timebase_in <= tb_div[4];
	end

	// count trimmed ticks
	always @(posedge aclk) begin
		if (timebase_tick_ff === 1'b1) tick_cnt <= tick_cnt + 1;
	end

	task complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	// bus write: address and data offered together, bready held until bvalid
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, wd, bd;
		ad = 1'b0;
		wd = 1'b0;
		bd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!bd) begin
			@(posedge aclk);
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				bd = 1'b1;
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
		chk("write order", 32'h1, {31'h0, ad && wd});
	endtask

	// bus read: rready held until rvalid
	task rd(input logic [7:0] a);
		logic ac, dn;
		ac = 1'b0;
		dn = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!dn) begin
			@(posedge aclk);
			if (!ac && s_axi_arready === 1'b1) begin
				ac = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				dn = 1'b1;
				rdat = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
		chk("read order", 32'h1, {31'h0, ac});
	endtask

	// config write, model follows; the window pointer field is taken as zero on readback here
	task cfg(input logic en, ch, input logic [3:0] mk, input logic [1:0] pt, input logic [7:0] rp);
		wr(`RTCA_OFF_CFG, {16'h0, en, ch, mk, pt, rp});
		m_en = en;
		m_ch = ch;
		m_mask = mk;
		m_rpt = rp;
	endtask

	task rdcfg;
		rd(`RTCA_OFF_CFG);
		chk("alarm config", {16'h0, m_en, m_ch, m_mask, 2'h0, m_rpt}, rdat);
	endtask

	// one half-second tick, then irq and pulse compared with the model
	task tick(input logic [47:0] now, input logic sp);
		logic fire;
		@(posedge aclk);
		time_now <= now;
		second_phase <= sp;
		half_tick <= 1'b1;
		@(posedge aclk);
		half_tick <= 1'b0;
		@(posedge aclk);
		fire = m_en && (m_mask == 4'h0 || (m_mask < 4'hA && sp &&
			((now ^ {m_md, m_wh, m_ms}) & cmpm[m_mask]) == 48'h0));
		if (fire) begin
			m_pulse = ~m_pulse;
			if (m_rpt != 8'h00) m_rpt = m_rpt - 8'h01;
			else if (m_ch) m_rpt = 8'hFF;
			else m_en = 1'b0;
		end
		chk("alarm irq", {31'h0, fire}, {31'h0, alarm_irq_ff});
		chk("alarm pulse", {31'h0, m_pulse}, {31'h0, alarm_pulse_ff});
		@(posedge aclk);
		chk("single irq", 32'h0, {31'h0, alarm_irq_ff});
	endtask

	// stop a hung run
	initial begin
		repeat (40000) @(posedge aclk);
		err_total++;
		$display("watchdog expired");
		complete_run;
	end

	initial begin
		logic [47:0] alm, fl, fi, impl;
		logic [15:0] bits [3];
		logic [15:0] mv [3];
		logic [7:0]  tr [3];
		int          k, c0;
		k = $urandom(25307);
		cmpm = '{0: 48'h0, 1: 48'h0, 2: 48'h000F, 3: 48'h007F, 4: 48'h0F7F, 5: 48'h7F7F,
			6: 48'h0000_003F_7F7F, 7: 48'h0000_073F_7F7F, 8: 48'h003F_003F_7F7F,
			9: 48'h1F3F_003F_7F7F, default: 48'h0};
		bits = '{`RTCA_MD_BITS, `RTCA_WH_BITS, `RTCA_MS_BITS};
		impl = {bits[0], bits[1], bits[2]};
		tr = '{8'h05, 8'hFD, 8'h00};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rdcfg;
		// write enable clear: month/day ignored, minute/second taken
		wr(`RTCA_OFF_MD, 32'hFFFF);
		chk("md write resp", {30'h0, `RTCA_RESP_OKAY}, {30'h0, rsp});
		rd(`RTCA_OFF_MD);
		chk("md locked", 32'h0, rdat);
		wr(`RTCA_OFF_MS, 32'hFFFF);
		rd(`RTCA_OFF_MS);
		chk("ms bits", 32'h7F7F, rdat);
		wr(`RTCA_OFF_CAL, 32'h8000);
		// random values through all three value registers, alarm still disabled
		for (k = 0; k < 3; k++) begin
			mv[k] = 16'($urandom());
			wr(8'h08 + 8'(4 * k), {16'hFFFF, mv[k]});
			mv[k] = mv[k] & bits[k];
			rd(8'h08 + 8'(4 * k));
			chk("value reg", {16'h0, mv[k]}, rdat);
		end
		// unmapped address
		wr(8'h1C, 32'h0);
		chk("unmapped write", {30'h0, `RTCA_RESP_SLVERR}, {30'h0, rsp});
		rd(8'h1C);
		chk("unmapped read", {30'h0, `RTCA_RESP_SLVERR}, {30'h0, rsp});
		// window pointer walks down and stops at zero
		cfg(1'b0, 1'b0, 4'h0, 2'h2, 8'h00);
		for (k = 0; k < 4; k++) begin
			rd(`RTCA_OFF_WIN);
			chk("window read", {16'h0, mv[k > 2 ? 2 : k]}, rdat);
		end
		rdcfg;
		// window write lands in the pair it points at, then the pointer steps down
		cfg(1'b0, 1'b0, 4'h0, 2'h1, 8'h00);
		mv[1] = ~mv[1] & bits[1];
		wr(`RTCA_OFF_WIN, {16'h0, mv[1]});
		rd(`RTCA_OFF_WH);
		chk("window write", {16'h0, mv[1]}, rdat);
		rdcfg;
		m_md = mv[0];
		m_wh = mv[1];
		m_ms = mv[2];
		// every mask code: wrong phase, compared digit off, ignored digit off, exact
		alm = {m_md, m_wh, m_ms};
		for (k = 0; k < 16; k++) begin
			cfg(1'b1, 1'b0, 4'(k), 2'h0, 8'h00);
			fl = impl & ~cmpm[k];
			fl = fl & (~fl + 48'h1);
			fi = cmpm[k] & (~cmpm[k] + 48'h1);
			tick(alm, 1'b0);
			tick(alm ^ fi, 1'b1);
			tick(alm ^ fl, 1'b1);
			tick(alm, 1'b1);
			rdcfg;
		end
		rd(`RTCA_OFF_STAT);
		chk("status pulse", {31'h0, m_pulse}, {31'h0, rdat[0]});
		// repeat count runs down, then enable clears
		cfg(1'b1, 1'b0, 4'h0, 2'h0, 8'h02);
		repeat (4) begin
			tick(alm, 1'b1);
			rdcfg;
		end
		// chime wraps the count and keeps the alarm alive
		cfg(1'b1, 1'b1, 4'h3, 2'h0, 8'h01);
		repeat (3) begin
			tick(alm, 1'b1);
			rdcfg;
		end
		cfg(1'b0, 1'b0, 4'h0, 2'h0, 8'h00);
		// trim: 64 raw ticks per window, shifted by four per trim step
		for (k = 0; k < 3; k++) begin
			wr(`RTCA_OFF_CAL, {16'h0000, 16'h8000 | 16'(tr[k])});
			@(posedge aclk);
			c0 = tick_cnt;
			minute_tick <= 1'b1;
			@(posedge aclk);
			minute_tick <= 1'b0;
			repeat (2047) @(posedge aclk);
			chk("trimmed ticks", 64 + 4 * $signed(tr[k]), tick_cnt - c0);
		end
		// trim with zero step leaves nothing pending
		rd(`RTCA_OFF_STAT);
		chk("trim idle", 32'h0, {31'h0, rdat[1]});
		complete_run;
	end

endmodule
